// ### inc/tcu_params.svh
// offsets, field positions, reset values and timing of the timer unit
`ifndef TCU_PARAMS_SVH
`define TCU_PARAMS_SVH

// register byte offsets on the bus
`define TCU_OFF_CTRL   8'h00
`define TCU_OFF_RLD1   8'h04
`define TCU_OFF_RLD2   8'h08
`define TCU_OFF_RLD3   8'h0C
`define TCU_OFF_CNT1   8'h10
`define TCU_OFF_CNT2   8'h14
`define TCU_OFF_CNT3   8'h18
`define TCU_OFF_CAPT   8'h1C
`define TCU_OFF_PEND   8'h20
`define TCU_OFF_VEC0   8'h40

// field positions
`define TCU_CTRL_MSB   12
`define TCU_CNT_MSB    7
`define TCU_PRE_LSB    8
`define TCU_PRE_MSB    12
`define TCU_PEND_LSB   1
`define TCU_PEND_MSB   5
`define TCU_LVL_LSB    8
`define TCU_LVL_MSB    10
`define TCU_IRQ_BIT    11
`define TCU_VEC_MSB    15

// reset values
`define TCU_CTRL_RST   13'h0000
`define TCU_VEC_RST    16'h0000

// timing: bus clock period and internal state cycle, in ns
`define TCU_CLK_NS     100
`define TCU_STATE_NS   200

`endif

// ### inc/tcu_pkg.sv
// types shared by the timer, capture and interrupt unit
package tcu_pkg;

  // software control word, packed msb first as stored in the register
  typedef struct packed {
    logic [4:0] ien;      // enables of levels 5..1
    logic       gie;      // global enable
    logic       t3_baud;  // timer 3 drives the serial bit rate
    logic       cascade;  // timer 2 clocked by timer 1 underflow
    logic [1:0] ext_src;  // timer 2/1 count event pins
    logic [2:0] run;      // start bits of timers 3..1
  } ctrl_t;

  // register selected by an address
  typedef enum {
    REG_CTRL, REG_RLD1, REG_RLD2, REG_RLD3, REG_CNT1, REG_CNT2,
    REG_CNT3, REG_CAPT, REG_PEND, REG_VEC, REG_NONE
  } reg_t;

  // state of one timer stage
  typedef struct packed {
    logic [7:0] cnt;
    logic [4:0] pre;
    logic       uf;
  } tstage_t;

  // state of the unit outside the three timer stages
  typedef struct packed {
    ctrl_t           ctrl;
    logic [7:0]      rld1;
    logic [7:0]      rld2;
    logic [7:0]      rld3;
    logic [4:0]      prl1;
    logic [4:0]      prl2;
    logic [1:0]      prl3;
    logic [7:0]      capture;
    logic [5:1]      pend;
    logic [5:0][15:0] vec;
    logic            wr_pend;
    logic [7:0]      wr_addr;
    logic [2:0]      load;
    logic [3:0]      div;
    logic            stick;
    logic            ext_irq_high_prio_q;
    logic            ext_irq_low_prio_q;
    logic            ev1_q;
    logic            ev2_q;
    logic            irq;
    logic [2:0]      lvl;
    logic [15:0]     ivec;
    logic            baud;
    logic [31:0]     rdata;
    logic            ready;
  } core_t;

endpackage

// ### hw/timer_stage.sv
// one countdown timer: prescaler and 8-bit counter, reloaded from the unit's latches
`timescale 1ns/100ps

module timer_stage
  import tcu_pkg::*;
#(
  parameter int PW = 5
) (
  input  wire logic          clk_i,     // bus clock
  input  wire logic          rst_i,     // async reset, high
  input  wire logic          run_i,     // start/stop bit
  input  wire logic          tick_i,    // count enable pulse
  input  wire logic          load_i,    // reload latch was written
  input  wire logic [7:0]    cnt_rld_i, // counter reload value
  input  wire logic [PW-1:0] pre_rld_i, // prescaler reload value
  output logic      [7:0]    cnt_o,     // counter value
  output logic      [PW-1:0] pre_o,     // prescaler value
  output logic               uf_o       // pulse: counted past zero
);

  tstage_t s_reg;
  tstage_t s_next;
  logic [4:0] pre_ext;

  // next state of the prescaler and counter chain
  always_comb begin
    pre_ext = 5'(pre_rld_i);
    s_next = s_reg;
    s_next.uf = 1'b0;
    if (load_i) begin
      s_next.cnt = cnt_rld_i;
      s_next.pre = pre_ext;
    end else if (run_i && tick_i) begin // R1
      if (s_reg.pre == 5'h00) begin // R2 R6
        s_next.pre = pre_ext;
        if (s_reg.cnt == 8'h00) begin
          s_next.cnt = cnt_rld_i; // R9
          s_next.uf = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01; // R8
        end
      end else begin
        s_next.pre = s_reg.pre - 5'h01;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cnt_o = s_reg.cnt;
  assign pre_o = s_reg.pre[PW-1:0];
  assign uf_o  = s_reg.uf;

endmodule

// ### hw/timer_capture_interrupt_unit.sv
// three timers, capture latch and vectored interrupt levels, AHB-Lite slave
//
// Function
// R1: each of three timers runs only while its own start bit is set.
// R2: timers 1 and 2 are 8-bit counters behind 5-bit prescalers.
// R3: timers 1 and 2 count state clock or their external event pin.
// R4: timers 1 and 2 with prescalers cascade into one 26-bit timer.
// R5: in cascade, each timer 1 underflow clocks the timer 2 prescaler.
// R6: timer 3 is an 8-bit counter behind a 2-bit prescaler.
// R7: timer 3 serves as general timer or as serial bit rate source.
// R8: all timers count down and restart from a software reload latch.
// R9: counting past zero reloads the timer from its latch automatically.
// R10: level 3 edge copies timer 1 count into the 8-bit capture latch.
// R11: six levels; level 0 is reset and cannot be masked.
// R12: levels 1 and 3 come from pins, on falling edges only.
// R13: timer 1 requests level 2, timer 2 requests level 5.
// R14: level 4 is shared by serial receive, serial transmit and timer 3.
// R15: every level branches through its own programmed vector.
// R16: a global enable and per-level enables gate levels 1 to 5.
// R17: the level 1 pin outranks the level 3 pin.
// R18: of several enabled pending levels the lowest number is served first.
// R19: timer 1 event counts arrive on the port A bit 7 pin.
// R20: timer 2 event counts arrive on the port A bit 6 pin.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "tcu_params.svh"

module timer_capture_interrupt_unit
  import tcu_pkg::*;
#(
  parameter int STATE_NS = `TCU_STATE_NS
) (
  input  wire logic        CLK_I,                // 10 MHz clock
  input  wire logic        RST_I,                // async reset, high
  input  wire logic        HSEL_I,               // slave select
  input  wire logic [31:0] HADDR_I,              // byte address
  input  wire logic [1:0]  HTRANS_I,             // transfer type
  input  wire logic        HWRITE_I,             // write when high
  input  wire logic [2:0]  HSIZE_I,              // word only
  input  wire logic [31:0] HWDATA_I,             // write data
  input  wire logic        HREADY_I,             // bus ready
  output logic      [31:0] HRDATA_O,             // read data
  output logic             HREADYOUT_O,          // slave ready
  output logic             HRESP_O,              // always okay
  input  wire logic        TIMER1_EVENT_INPUT_I, // timer 1 event pin
  input  wire logic        TIMER2_EVENT_INPUT_I, // timer 2 event pin
  input  wire logic        EXT_IRQ_HIGH_PRIO_I,  // level 1 pin
  input  wire logic        EXT_IRQ_LOW_PRIO_I,   // level 3 pin
  input  wire logic        SER_RX_EVENT_I,       // serial receive pulse
  input  wire logic        SER_TX_EVENT_I,       // serial transmit pulse
  input  wire logic        IRQ_ACK_I,            // cpu took the level
  output logic             IRQ_O,                // request to cpu
  output logic      [2:0]  IRQ_LEVEL_O,          // level being requested
  output logic      [15:0] IRQ_VECTOR_O,         // vector of that level
  output logic             BAUD_TICK_O           // serial bit rate pulse
);

  // state clock divider length derived from the two periods
  localparam int DIV_I = (STATE_NS + `TCU_CLK_NS - 1) / `TCU_CLK_NS;
  localparam logic [3:0] DIV_LAST = 4'((DIV_I < 1) ? 0 : DIV_I - 1);

  core_t s_reg;
  core_t s_next;

  logic [7:0] cnt1;
  logic [7:0] cnt2;
  logic [7:0] cnt3;
  logic [4:0] pre1;
  logic [4:0] pre2;
  logic [1:0] pre3;
  logic       uf1;
  logic       uf2;
  logic       uf3;
  logic       tick1;
  logic       tick2;
  logic       f_ext_irq_high_prio;
  logic       f_ext_irq_low_prio;
  logic [5:1] src;
  logic [5:1] clr;
  logic [5:1] masked;
  logic [2:0] sel_lvl;
  logic       take;

  // falling edge of a synchronous pin against its previous sample
  function automatic logic fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  // address decode shared by read and write
  function automatic reg_t reg_sel(input logic [7:0] a);
    reg_t r;
    r = REG_NONE;
    case (a)
      `TCU_OFF_CTRL: r = REG_CTRL;
      `TCU_OFF_RLD1: r = REG_RLD1;
      `TCU_OFF_RLD2: r = REG_RLD2;
      `TCU_OFF_RLD3: r = REG_RLD3;
      `TCU_OFF_CNT1: r = REG_CNT1;
      `TCU_OFF_CNT2: r = REG_CNT2;
      `TCU_OFF_CNT3: r = REG_CNT3;
      `TCU_OFF_CAPT: r = REG_CAPT;
      `TCU_OFF_PEND: r = REG_PEND;
      default: begin
        if (a[7:5] == `TCU_OFF_VEC0 >> 5 && a[4:2] < 3'h6 && a[1:0] == 2'h0)
          r = REG_VEC;
      end
    endcase
    return r;
  endfunction

  // event sources, each pin edge from its registered sample and the live pin
  assign f_ext_irq_high_prio = fell(s_reg.ext_irq_high_prio_q, EXT_IRQ_HIGH_PRIO_I); // R12
  assign f_ext_irq_low_prio = fell(s_reg.ext_irq_low_prio_q, EXT_IRQ_LOW_PRIO_I);  // R12

  // timer clocking: state clock, event pin, or cascade from timer 1
  assign tick1 = s_reg.ctrl.ext_src[0] ?
                 fell(s_reg.ev1_q, TIMER1_EVENT_INPUT_I) : // R3 R19
                 s_reg.stick;
  assign tick2 = s_reg.ctrl.cascade ? uf1 :                // R4 R5
                 s_reg.ctrl.ext_src[1] ?
                 fell(s_reg.ev2_q, TIMER2_EVENT_INPUT_I) : // R3 R20
                 s_reg.stick;

  timer_stage #(.PW(5)) u_t1 (
    .clk_i     (CLK_I),
    .rst_i     (RST_I),
    .run_i     (s_reg.ctrl.run[0]),
    .tick_i    (tick1),
    .load_i    (s_reg.load[0]),
    .cnt_rld_i (s_reg.rld1),
    .pre_rld_i (s_reg.prl1),
    .cnt_o     (cnt1),
    .pre_o     (pre1),
    .uf_o      (uf1)
  );

  timer_stage #(.PW(5)) u_t2 (
    .clk_i     (CLK_I),
    .rst_i     (RST_I),
    .run_i     (s_reg.ctrl.run[1]),
    .tick_i    (tick2),
    .load_i    (s_reg.load[1]),
    .cnt_rld_i (s_reg.rld2),
    .pre_rld_i (s_reg.prl2),
    .cnt_o     (cnt2),
    .pre_o     (pre2),
    .uf_o      (uf2)
  );

  timer_stage #(.PW(2)) u_t3 (
    .clk_i     (CLK_I),
    .rst_i     (RST_I),
    .run_i     (s_reg.ctrl.run[2]),
    .tick_i    (s_reg.stick),
    .load_i    (s_reg.load[2]),
    .cnt_rld_i (s_reg.rld3),
    .pre_rld_i (s_reg.prl3),
    .cnt_o     (cnt3),
    .pre_o     (pre3),
    .uf_o      (uf3)
  );

  // request sources per level; level 0 is the reset itself
  assign src[1] = f_ext_irq_high_prio;                                    // R12
  assign src[2] = uf1;                                       // R13
  assign src[3] = f_ext_irq_low_prio;                                    // R12
  assign src[4] = SER_RX_EVENT_I | SER_TX_EVENT_I |
                  (uf3 & ~s_reg.ctrl.t3_baud);               // R14 R7
  assign src[5] = uf2;                                       // R13
  assign masked = s_reg.pend & s_reg.ctrl.ien &
                  {5{s_reg.ctrl.gie}};                       // R16
  assign take   = HSEL_I & HREADY_I & HTRANS_I[1];

  // lowest numbered enabled level wins, so pin 1 beats pin 3
  always_comb begin
    sel_lvl = 3'h0;
    for (int k = 5; k >= 1; k--) begin
      if (masked[k]) sel_lvl = 3'(k); // R17 R18
    end
  end

  // clears: write one to pending bits, or acknowledge of the served level
  always_comb begin
    clr = '0;
    if (s_reg.wr_pend && reg_sel(s_reg.wr_addr) == REG_PEND)
      clr = HWDATA_I[`TCU_PEND_MSB:`TCU_PEND_LSB];
    for (int k = 1; k <= 5; k++) begin
      if (IRQ_ACK_I && s_reg.irq && s_reg.lvl == 3'(k)) clr[k] = 1'b1;
    end
  end

  // next state of the whole unit
  always_comb begin
    s_next = s_reg;
    s_next.load = 3'h0;
    s_next.ext_irq_high_prio_q = EXT_IRQ_HIGH_PRIO_I;
    s_next.ext_irq_low_prio_q = EXT_IRQ_LOW_PRIO_I;
    s_next.ev1_q = TIMER1_EVENT_INPUT_I;
    s_next.ev2_q = TIMER2_EVENT_INPUT_I;
    // state clock enable
    s_next.stick = (s_reg.div == DIV_LAST);
    s_next.div = s_next.stick ? 4'h0 : s_reg.div + 4'h1;
    // capture timer 1 on the level 3 edge
    if (f_ext_irq_low_prio) s_next.capture = cnt1; // R10
    // pending flags: a new event beats a clear in the same cycle
    s_next.pend = (s_reg.pend & ~clr) | src;
    // interrupt request with its vector
    s_next.irq = |masked;
    s_next.lvl = sel_lvl;                  // R11
    s_next.ivec = s_reg.vec[sel_lvl];      // R15
    s_next.baud = uf3 & s_reg.ctrl.t3_baud; // R7
    // bus write data phase
    if (s_reg.wr_pend) begin
      s_next.wr_pend = 1'b0;
      case (reg_sel(s_reg.wr_addr))
        REG_CTRL: s_next.ctrl = ctrl_t'(HWDATA_I[`TCU_CTRL_MSB:0]); // R1
        REG_RLD1: begin
          s_next.rld1 = HWDATA_I[`TCU_CNT_MSB:0]; // R8
          s_next.prl1 = HWDATA_I[`TCU_PRE_MSB:`TCU_PRE_LSB];
          s_next.load[0] = 1'b1;
        end
        REG_RLD2: begin
          s_next.rld2 = HWDATA_I[`TCU_CNT_MSB:0]; // R8
          s_next.prl2 = HWDATA_I[`TCU_PRE_MSB:`TCU_PRE_LSB];
          s_next.load[1] = 1'b1;
        end
        REG_RLD3: begin
          s_next.rld3 = HWDATA_I[`TCU_CNT_MSB:0]; // R8
          s_next.prl3 = HWDATA_I[`TCU_PRE_LSB+1:`TCU_PRE_LSB];
          s_next.load[2] = 1'b1;
        end
        REG_VEC: s_next.vec[s_reg.wr_addr[4:2]] =
                   HWDATA_I[`TCU_VEC_MSB:0]; // R15
        default: s_next.wr_pend = 1'b0;
      endcase
    end
    // bus address phase: latch writes, fetch reads
    if (take && HWRITE_I) begin
      s_next.wr_pend = 1'b1;
      s_next.wr_addr = HADDR_I[7:0];
    end
    if (take && !HWRITE_I) begin
      s_next.rdata = 32'h0000_0000;
      case (reg_sel(HADDR_I[7:0]))
        REG_CTRL: s_next.rdata[`TCU_CTRL_MSB:0] = s_reg.ctrl;
        REG_RLD1: s_next.rdata[`TCU_PRE_MSB:0] = {s_reg.prl1, s_reg.rld1};
        REG_RLD2: s_next.rdata[`TCU_PRE_MSB:0] = {s_reg.prl2, s_reg.rld2};
        REG_RLD3: s_next.rdata[`TCU_PRE_LSB+1:0] = {s_reg.prl3, s_reg.rld3};
        REG_CNT1: s_next.rdata[`TCU_PRE_MSB:0] = {pre1, cnt1};
        REG_CNT2: s_next.rdata[`TCU_PRE_MSB:0] = {pre2, cnt2};
        REG_CNT3: s_next.rdata[`TCU_PRE_LSB+1:0] = {pre3, cnt3};
        REG_CAPT: s_next.rdata[`TCU_CNT_MSB:0] = s_reg.capture;
        REG_PEND: begin
          s_next.rdata[`TCU_PEND_MSB:`TCU_PEND_LSB] = s_reg.pend;
          s_next.rdata[`TCU_LVL_MSB:`TCU_LVL_LSB] = s_reg.lvl;
          s_next.rdata[`TCU_IRQ_BIT] = s_reg.irq;
        end
        REG_VEC: s_next.rdata[`TCU_VEC_MSB:0] = s_reg.vec[HADDR_I[4:2]];
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register; reset stands for level 0 and uses vector 0
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s_reg <= '0;
      s_reg.ctrl <= `TCU_CTRL_RST;
      s_reg.vec <= {6{`TCU_VEC_RST}};
      s_reg.ivec <= `TCU_VEC_RST; // R11
      s_reg.ready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register, HRESP_O tied low
  assign HRDATA_O     = s_reg.rdata;
  assign HREADYOUT_O  = s_reg.ready;
  assign HRESP_O      = 1'b0;
  assign IRQ_O        = s_reg.irq;
  assign IRQ_LEVEL_O  = s_reg.lvl;
  assign IRQ_VECTOR_O = s_reg.ivec;
  assign BAUD_TICK_O  = s_reg.baud;

  // helper: lowest set bit of the enabled pending set
  logic [5:1] low_one;
  assign low_one = masked & ~(masked - 5'h01);

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  a_capture_on_edge: assert property ( // R10
    f_ext_irq_low_prio |=> s_reg.capture == $past(cnt1))
    else $error("capture latch missed timer 1 value");

  a_pin_edge_only: assert property ( // R12
    !s_reg.pend[1] && !f_ext_irq_high_prio |=> !s_reg.pend[1])
    else $error("level 1 set without falling edge");

  a_timer1_level2: assert property ( // R13
    uf1 |=> s_reg.pend[2])
    else $error("timer 1 underflow did not set level 2");

  a_timer2_level5: assert property ( // R13
    uf2 |=> s_reg.pend[5])
    else $error("timer 2 underflow did not set level 5");

  a_serial_level4: assert property ( // R14
    SER_RX_EVENT_I || SER_TX_EVENT_I |=> s_reg.pend[4])
    else $error("serial event did not set level 4");

  a_global_gate: assert property ( // R16
    !s_reg.ctrl.gie |=> !IRQ_O)
    else $error("request raised with global enable off");

  a_lowest_served: assert property ( // R18
    masked != 5'h00 |=> IRQ_O &&
      $past(low_one) == 5'(5'h01 << (IRQ_LEVEL_O - 3'h1)))
    else $error("served level is not the lowest pending");

  a_vector_follows: assert property ( // R15
    $stable(s_reg.vec) |-> IRQ_VECTOR_O == s_reg.vec[IRQ_LEVEL_O])
    else $error("vector does not match served level");

  a_reload_value: assert property ( // R9
    uf1 |-> cnt1 == $past(s_reg.rld1))
    else $error("timer 1 not reloaded after zero");

  a_cascade_hold: assert property ( // R5
    s_reg.ctrl.cascade && !uf1 && !s_reg.load[1]
      |=> $stable(cnt2) && $stable(pre2))
    else $error("timer 2 moved without timer 1 underflow");

  a_baud_pulse: assert property ( // R7
    uf3 |=> BAUD_TICK_O == $past(s_reg.ctrl.t3_baud))
    else $error("bit rate pulse wrong for timer 3 mode");

  c_cascade_wrap: cover property (s_reg.ctrl.cascade && uf2);
  c_capture: cover property (f_ext_irq_low_prio && s_reg.ctrl.run[0]);
  c_level4_irq: cover property (IRQ_O && IRQ_LEVEL_O == 3'h4);

endmodule

// ### tb/event_source_model.sv
// event pins, interrupt pins and serial pulses that feed the timer unit
`timescale 1ns/100ps

module event_source_model (
  input  wire logic clk_i, // bus clock
  output logic      ev1_o, // timer 1 event pin, idles high
  output logic      ev2_o, // timer 2 event pin, idles high
  output logic      hi_o,  // level 1 pin, idles high
  output logic      lo_o,  // level 3 pin, idles high
  output logic      rx_o,  // serial receive pulse
  output logic      tx_o   // serial transmit pulse
);
  // pins rest high, pulses rest low
  initial begin
    ev1_o = 1'b1;
    ev2_o = 1'b1;
    hi_o  = 1'b1;
    lo_o  = 1'b1;
    rx_o  = 1'b0;
    tx_o  = 1'b0;
  end

  // one event: low for two samples, then high for two
  task automatic event_pulse(input int pin);
    if (pin == 1) begin
      ev1_o <= 1'b0;
    end else begin
      ev2_o <= 1'b0;
    end
    repeat (2) @(posedge clk_i);
    ev1_o <= 1'b1;
    ev2_o <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask

  // both interrupt pins fall together
  task automatic irq_fall;
    hi_o <= 1'b0;
    lo_o <= 1'b0;
    @(posedge clk_i);
  endtask

  // both interrupt pins return high
  task automatic irq_rise;
    hi_o <= 1'b1;
    lo_o <= 1'b1;
    @(posedge clk_i);
  endtask

  // one-cycle serial receive or transmit pulse
  task automatic serial(input logic r);
    rx_o <= r;
    tx_o <= ~r;
    @(posedge clk_i);
    rx_o <= 1'b0;
    tx_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule

// ### tb/tb_timer_capture_interrupt_unit.sv
// self-checking bench for the timer, capture and interrupt unit
`timescale 1ns/100ps
`include "tcu_params.svh"

module tb_timer_capture_interrupt_unit;
  logic        clk;
  logic        rst;
  logic        hsel;
  logic        hwrite;
  logic        ack;
  logic        hready;
  logic        hresp;
  logic        irq;
  logic        baud;
  logic        ev1, ev2, ihi, ilo, rx, tx;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [2:0]  lvl;
  logic [15:0] vec;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rows [12][3];
  int          miscompares;
  int          n_tests;
  int          n;

  timer_capture_interrupt_unit #(.STATE_NS(100))
  timer_capture_interrupt_unit_i (
    .CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp),
    .TIMER1_EVENT_INPUT_I(ev1), .TIMER2_EVENT_INPUT_I(ev2),
    .EXT_IRQ_HIGH_PRIO_I(ihi), .EXT_IRQ_LOW_PRIO_I(ilo),
    .SER_RX_EVENT_I(rx), .SER_TX_EVENT_I(tx), .IRQ_ACK_I(ack),
    .IRQ_O(irq), .IRQ_LEVEL_O(lvl), .IRQ_VECTOR_O(vec), .BAUD_TICK_O(baud)
  );

  event_source_model event_source_model_i (
    .clk_i(clk), .ev1_o(ev1), .ev2_o(ev2), .hi_o(ihi), .lo_o(ilo),
    .rx_o(rx), .tx_o(tx)
  );

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // hang guard, far beyond the few hundred cycles of the run
  initial begin
    #1000000;
    miscompares++;
    conclude();
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic check_n(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      miscompares++;
      $display("mismatch at %0t: count %0d want %0d", $time, got, exp);
    end
  endtask

  // one single-word transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    hsize  <= 3'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    check32(r, e);
  endtask

  // stop all, load a reload latch, clear pending, then set control
  task automatic start(input logic [7:0] a, input logic [31:0] r,
                       input logic [31:0] c);
    wr(`TCU_OFF_CTRL, 32'h0000_0000);
    wr(a, r);
    wr(`TCU_OFF_PEND, 32'h0000_003E);
    wr(`TCU_OFF_CTRL, c);
  endtask

  // edges until the request shows, bounded
  task automatic wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
  endtask

  // acknowledge the shown level and let the request fall
  task automatic take;
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic see(input logic [2:0] l, input logic [15:0] v);
    check32({12'h000, irq, lvl, vec}, {12'h000, 1'b1, l, v});
  endtask

  // rise to rise distance of a periodic request
  task automatic period(input logic [2:0] l, input logic [15:0] v,
                        input int p);
    wait_irq();
    take();
    wait_irq();
    see(l, v);
    check_n(n + 4, p);
    take();
  endtask

  initial begin
    rst    = 1'b1;
    hsel   = 1'b0;
    htrans = 2'b00;
    hsize  = 3'h2;
    haddr  = 32'h0000_0000;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    ack    = 1'b0;
    miscompares = 0;
    n_tests = 0;
    rows = '{
      '{32'h0000_0000, 32'hFFFF_FF78, 32'h0000_1F78},
      '{32'h0000_0004, 32'hFFFF_FFFF, 32'h0000_1FFF},
      '{32'h0000_0008, 32'hFFFF_FFFF, 32'h0000_1FFF},
      '{32'h0000_000C, 32'hFFFF_FFFF, 32'h0000_03FF},
      '{32'h0000_0040, 32'hFFFF_C0D0, 32'h0000_C0D0},
      '{32'h0000_0044, 32'hFFFF_C0D1, 32'h0000_C0D1},
      '{32'h0000_0048, 32'hFFFF_C0D2, 32'h0000_C0D2},
      '{32'h0000_004C, 32'hFFFF_C0D3, 32'h0000_C0D3},
      '{32'h0000_0050, 32'hFFFF_C0D4, 32'h0000_C0D4},
      '{32'h0000_0054, 32'hFFFF_C0D5, 32'h0000_C0D5},
      '{32'h0000_0030, 32'hFFFF_FFFF, 32'h0000_0000},
      '{32'h0000_0058, 32'hFFFF_FFFF, 32'h0000_0000}
    };
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // register rows: write, read back
    foreach (rows[i]) begin
      wr(rows[i][0][7:0], rows[i][1]);
      rd(rows[i][0][7:0], rows[i][2]);
    end
    // timer 1 on state ticks, period (1+1)*(2+1)
    start(`TCU_OFF_RLD1, 32'h0000_0102, 32'h0000_0281);
    period(3'd2, 16'hC0D2, 6);
    // timer 1 on its event pin, three falling edges
    start(`TCU_OFF_RLD1, 32'h0000_0002, 32'h0000_0289);
    repeat (2) event_source_model_i.event_pulse(1);
    check32(32'(irq), 32'h0000_0000);
    event_source_model_i.event_pulse(1);
    wait_irq();
    see(3'd2, 16'hC0D2);
    take();
    // timer 2 on its event pin, one edge
    start(`TCU_OFF_RLD2, 32'h0000_0000, 32'h0000_1092);
    event_source_model_i.event_pulse(2);
    wait_irq();
    see(3'd5, 16'hC0D5);
    take();
    // cascade: timer 1 every 2 ticks, timer 2 every 3 of those
    wr(`TCU_OFF_RLD1, 32'h0000_0100);
    start(`TCU_OFF_RLD2, 32'h0000_0002, 32'h0000_10A3);
    period(3'd5, 16'hC0D5, 6);
    // timer 3 general, period (3+1)*(1+1)
    start(`TCU_OFF_RLD3, 32'h0000_0301, 32'h0000_0884);
    period(3'd4, 16'hC0D4, 8);
    // timer 3 as bit rate source: pulses, no request
    start(`TCU_OFF_RLD3, 32'h0000_0301, 32'h0000_08C4);
    repeat (12) @(posedge clk);
    n = 0;
    repeat (80) begin
      @(posedge clk);
      n += int'(baud === 1'b1);
    end
    check_n(n, 10);
    rd(`TCU_OFF_PEND, 32'h0000_0000);
    // both pins fall with timer 1 stopped, levels masked
    start(`TCU_OFF_RLD1, 32'h0000_005A, 32'h0000_0080);
    event_source_model_i.irq_fall();
    repeat (4) @(posedge clk);
    check32(32'(irq), 32'h0000_0000);
    rd(`TCU_OFF_PEND, 32'h0000_000A);
    rd(`TCU_OFF_CAPT, 32'h0000_005A);
    rd(`TCU_OFF_CNT1, 32'h0000_005A);
    wr(`TCU_OFF_CTRL, 32'h0000_0580);
    wait_irq();
    see(3'd1, 16'hC0D1);
    take();
    wait_irq();
    see(3'd3, 16'hC0D3);
    take();
    event_source_model_i.irq_rise();
    repeat (4) @(posedge clk);
    rd(`TCU_OFF_PEND, 32'h0000_0000);
    // serial receive then transmit share level 4
    wr(`TCU_OFF_CTRL, 32'h0000_0880);
    for (int i = 0; i < 2; i++) begin
      event_source_model_i.serial(i == 0);
      wait_irq();
      see(3'd4, 16'hC0D4);
      take();
    end
    // reset in mid-run with a request standing
    event_source_model_i.serial(1'b1);
    repeat (3) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    check32({12'h000, irq, lvl, vec}, 32'h0000_0000);
    check32({30'h0000_0000, hready, hresp}, 32'h0000_0002);
    rst <= 1'b0;
    rd(`TCU_OFF_CTRL, 32'h0000_0000);
    rd(`TCU_OFF_PEND, 32'h0000_0000);
    rd(8'h44, 32'h0000_0000);
    conclude();
  end
endmodule
